// ==== logic/burst_reconfig_pkg.sv ====
// constants shared by the burst reconfiguration logic
package burst_reconfig_pkg;
    localparam int CLK_NS = 100;
    localparam logic [13:0] CLK_KHZ = 14'h2710;
    localparam logic [11:0] RATE_BASE_KSYM = 12'h0a0;
    localparam logic [15:0] GAP_MIN_SYM = 16'h0060;
    localparam logic [26:0] PWR_SMALL_NS = 27'h0001388;
    localparam logic [26:0] PWR_BIG_NS = 27'h0002710;
    localparam logic [26:0] CHAN_NS = 27'h5f5e100;
    localparam logic [23:0] PWR_SMALL_CYC = 24'((int'(PWR_SMALL_NS) + CLK_NS - 1) / CLK_NS);
    localparam logic [23:0] PWR_BIG_CYC = 24'((int'(PWR_BIG_NS) + CLK_NS - 1) / CLK_NS);
    localparam int CHAN_SETTLE_CYC = int'(CHAN_NS) / CLK_NS;
    localparam logic [19:0] NS_PER_MS = 20'hf4240;
    localparam logic [5:0] PWR_MIN_DBMV = 6'h08;
    localparam logic [5:0] PWR_MAX_QAM16_DBMV = 6'h37;
    localparam logic [5:0] PWR_MAX_QPSK_DBMV = 6'h3a;
    localparam logic [5:0] PWR_RESET_DBMV = 6'h08;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [7:0] RAMP_SYM_DEFAULT = 8'h0a;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_RAMP = 4'b0010,
        S_APPLY = 4'b0100,
        S_SETTLE = 4'b1000
    } state_t;
endpackage

// ==== logic/symbol_tick_gen.sv ====
// symbol-rate enable pulse from the 10 MHz clock by fractional division
`timescale 1ns/1ps
`default_nettype none
module symbol_tick_gen
    import burst_reconfig_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] rate_code_in,
    output logic tick_out
);
    logic [13:0] acc;
    logic [13:0] next_acc;
    logic next_tick;
    logic [13:0] sum;

    always_comb begin
        sum = acc + 14'(RATE_BASE_KSYM << rate_code_in);
        next_tick = (sum >= CLK_KHZ);
        next_acc = next_tick ? 14'(sum - CLK_KHZ) : sum;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc <= 14'h0000;
            tick_out <= 1'b0;
        end else begin
            acc <= next_acc;
            tick_out <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ==== logic/power_step_quant.sv ====
// rounds a quarter-dB power step to whole dB, ties toward zero
`timescale 1ns/1ps
`default_nettype none
module power_step_quant (
    input wire logic signed [7:0] step_qdb_in,
    output logic signed [6:0] step_db_out
);
    logic [8:0] mag;
    logic [6:0] whole;

    always_comb begin
        mag = step_qdb_in[7] ? 9'(-{step_qdb_in[7], step_qdb_in}) : {1'b0, step_qdb_in};
        // 1 db resolution; above half rounds up, exact half rounds down
        whole = 7'(mag[8:2]) + ((mag[1:0] == 2'h3) ? 7'h01 : 7'h00);
        step_db_out = step_qdb_in[7] ? -$signed(whole) : $signed(whole);
    end
endmodule
`default_nettype wire

// ==== logic/upstream_burst_reconfig_power.sv ====
// inter-burst reconfiguration sequencer for the upstream transmitter
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - symbol rate, offset frequency or ranging offset changes go ahead when the gap is 96 symbols.
// - modulation changes go ahead when the gap between bursts is at least 96 symbols.
// - any change is held back until the scheduler grants a long enough gap.
// - settings switch only after the old burst has ramped down and before the next ramps up.
// - modulation switches in that same quiet window, pre-equalizer ignored.
// - a channel change needs 96 symbols plus 100 ms and settles within 100 ms.
// - a power change of 1 dB or less needs 96 symbols plus 5 us.
// - a power change above 1 dB needs 96 symbols plus 10 us.
// - power spans 8 dBmV to 55 (16qam) or 58 (qpsk) dBmV in 1 dB steps.
// - power step resolution is 1 dB.
// - finer power steps round to the nearest whole dB.
// - an exact half step rounds to the smaller step.
// - power stays constant throughout a burst.
// - a negative ranging adjustment lowers the ranging offset.
// - profile switches with no parameter change need no gap.
module upstream_burst_reconfig_power
    import burst_reconfig_pkg::*;
#(
    parameter int CHAN_SETTLE_CYCLES = CHAN_SETTLE_CYC,
    parameter logic [7:0] RAMP_SYMBOLS = RAMP_SYM_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic burst_end_in,
    input wire logic [15:0] gap_sym_in,
    input wire logic [2:0] next_rate_in,
    input wire logic signed [15:0] next_offset_freq_in,
    input wire logic signed [15:0] rng_adj_in,
    input wire logic next_qam16_in,
    input wire logic [31:0] next_chan_in,
    input wire logic signed [7:0] pwr_step_qdb_in,
    output logic [2:0] rate_out,
    output logic signed [15:0] offset_freq_out,
    output logic [15:0] rng_offset_out,
    output logic qam16_out,
    output logic [31:0] chan_out,
    output logic [5:0] power_out,
    output logic apply_out,
    output logic busy_out,
    output logic deferred_out
);
    // ------------------------------------------------------------
    // change detection and gap check
    // ------------------------------------------------------------
    state_t state;
    state_t next_state;
    logic sym_tick;
    logic signed [6:0] step_db;
    logic [11:0] rate_k;
    logic [5:0] pwr_max;
    logic signed [8:0] pwr_sum;
    logic [5:0] pwr_target;
    logic [5:0] pwr_delta;
    logic chg_rate, chg_off, chg_rng, chg_mod, chg_chan, chg_pwr, chg_any;
    logic [26:0] allow_ns;
    logic [23:0] allow_cyc;
    logic [47:0] gap_ns_room;
    logic [47:0] need_ns_room;
    logic gap_ok;

    symbol_tick_gen u_tick (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .rate_code_in(rate_out),
        .tick_out(sym_tick)
    );

    power_step_quant u_quant (
        .step_qdb_in(pwr_step_qdb_in),
        .step_db_out(step_db)
    );

    always_comb begin
        rate_k = 12'(RATE_BASE_KSYM << rate_out);
        pwr_max = next_qam16_in ? PWR_MAX_QAM16_DBMV : PWR_MAX_QPSK_DBMV;
        pwr_sum = $signed({3'b000, power_out}) + 9'(step_db);
        if (pwr_sum < $signed({3'b000, PWR_MIN_DBMV})) begin
            pwr_target = PWR_MIN_DBMV;
        end else if (pwr_sum > $signed({3'b000, pwr_max})) begin
            pwr_target = pwr_max;
        end else begin
            pwr_target = pwr_sum[5:0];
        end
        pwr_delta = (pwr_target > power_out) ? pwr_target - power_out : power_out - pwr_target;
        chg_rate = next_rate_in != rate_out;
        chg_off = next_offset_freq_in != offset_freq_out;
        chg_rng = rng_adj_in != 16'sh0000;
        chg_mod = next_qam16_in != qam16_out;
        chg_chan = next_chan_in != chan_out;
        chg_pwr = pwr_target != power_out;
        chg_any = chg_rate | chg_off | chg_rng | chg_mod | chg_chan | chg_pwr;
        // largest fixed allowance of all parameters changing
        if (chg_chan) begin
            allow_ns = CHAN_NS;
            allow_cyc = 24'(CHAN_SETTLE_CYCLES);
        end else if (chg_pwr && pwr_delta > 6'h01) begin
            allow_ns = PWR_BIG_NS;
            allow_cyc = PWR_BIG_CYC;
        end else if (chg_pwr) begin
            allow_ns = PWR_SMALL_NS;
            allow_cyc = PWR_SMALL_CYC;
        end else begin
            allow_ns = 27'h0000000;
            allow_cyc = 24'h000000;
        end
        // scheduler guard already covers negative ranging moves
        gap_ns_room = 48'(gap_sym_in - GAP_MIN_SYM) * 48'(NS_PER_MS);
        need_ns_room = 48'(allow_ns) * 48'(rate_k);
        gap_ok = (gap_sym_in >= GAP_MIN_SYM) && (gap_ns_room >= need_ns_room);
    end

    // ------------------------------------------------------------
    // staged settings and sequencer
    // ------------------------------------------------------------
    logic [2:0] stg_rate, next_stg_rate;
    logic signed [15:0] stg_off, next_stg_off;
    logic signed [15:0] stg_adj, next_stg_adj;
    logic stg_mod, next_stg_mod;
    logic [31:0] stg_chan, next_stg_chan;
    logic [5:0] stg_pwr, next_stg_pwr;
    logic [23:0] stg_cyc, next_stg_cyc;
    logic [7:0] ramp_cnt, next_ramp_cnt;
    logic [23:0] settle_cnt, next_settle_cnt;
    logic [2:0] next_rate;
    logic signed [15:0] next_offset_freq;
    logic [15:0] next_rng_offset;
    logic next_qam16;
    logic [31:0] next_chan;
    logic [5:0] next_power;
    logic next_apply, next_busy, next_deferred;
    logic signed [17:0] rng_sum;

    always_comb begin
        next_state = state;
        next_stg_rate = stg_rate;
        next_stg_off = stg_off;
        next_stg_adj = stg_adj;
        next_stg_mod = stg_mod;
        next_stg_chan = stg_chan;
        next_stg_pwr = stg_pwr;
        next_stg_cyc = stg_cyc;
        next_ramp_cnt = ramp_cnt;
        next_settle_cnt = settle_cnt;
        next_rate = rate_out;
        next_offset_freq = offset_freq_out;
        next_rng_offset = rng_offset_out;
        next_qam16 = qam16_out;
        next_chan = chan_out;
        next_power = power_out;
        next_apply = 1'b0;
        next_deferred = deferred_out;
        rng_sum = 18'($signed({2'b00, rng_offset_out})) + 18'(stg_adj);
        case (state)
            S_IDLE: begin
                if (burst_end_in && chg_any) begin
                    if (gap_ok) begin
                        next_state = S_RAMP;
                        next_deferred = 1'b0;
                        next_stg_rate = next_rate_in;
                        next_stg_off = next_offset_freq_in;
                        next_stg_adj = rng_adj_in;
                        next_stg_mod = next_qam16_in;
                        next_stg_chan = next_chan_in;
                        next_stg_pwr = pwr_target;
                        next_stg_cyc = allow_cyc;
                        next_ramp_cnt = RAMP_SYMBOLS;
                    end else begin
                        next_deferred = 1'b1;
                    end
                end else if (burst_end_in) begin
                    next_deferred = 1'b0;
                end
            end
            S_RAMP: begin
                // wait out the old burst's tail at its own rate
                if (ramp_cnt == 8'h00) begin
                    next_state = S_APPLY;
                end else if (sym_tick) begin
                    next_ramp_cnt = ramp_cnt - 8'h01;
                end
            end
            S_APPLY: begin
                next_rate = stg_rate;
                next_offset_freq = stg_off;
                next_qam16 = stg_mod;
                next_chan = stg_chan;
                next_power = stg_pwr;
                if (rng_sum < 18'sh00000) begin
                    next_rng_offset = 16'h0000;
                end else if (rng_sum > 18'sh0ffff) begin
                    next_rng_offset = 16'hffff;
                end else begin
                    next_rng_offset = rng_sum[15:0];
                end
                next_apply = 1'b1;
                next_settle_cnt = stg_cyc;
                next_state = S_SETTLE;
            end
            S_SETTLE: begin
                if (settle_cnt == 24'h000000) begin
                    next_state = S_IDLE;
                end else begin
                    next_settle_cnt = settle_cnt - 24'h000001;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        next_busy = next_state != S_IDLE;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= S_IDLE;
            stg_rate <= RATE_RESET;
            stg_off <= 16'sh0000;
            stg_adj <= 16'sh0000;
            stg_mod <= 1'b0;
            stg_chan <= 32'h00000000;
            stg_pwr <= PWR_RESET_DBMV;
            stg_cyc <= 24'h000000;
            ramp_cnt <= 8'h00;
            settle_cnt <= 24'h000000;
            rate_out <= RATE_RESET;
            offset_freq_out <= 16'sh0000;
            rng_offset_out <= 16'h0000;
            qam16_out <= 1'b0;
            chan_out <= 32'h00000000;
            power_out <= PWR_RESET_DBMV;
            apply_out <= 1'b0;
            busy_out <= 1'b0;
            deferred_out <= 1'b0;
        end else begin
            state <= next_state;
            stg_rate <= next_stg_rate;
            stg_off <= next_stg_off;
            stg_adj <= next_stg_adj;
            stg_mod <= next_stg_mod;
            stg_chan <= next_stg_chan;
            stg_pwr <= next_stg_pwr;
            stg_cyc <= next_stg_cyc;
            ramp_cnt <= next_ramp_cnt;
            settle_cnt <= next_settle_cnt;
            rate_out <= next_rate;
            offset_freq_out <= next_offset_freq;
            rng_offset_out <= next_rng_offset;
            qam16_out <= next_qam16;
            chan_out <= next_chan;
            power_out <= next_power;
            apply_out <= next_apply;
            busy_out <= next_busy;
            deferred_out <= next_deferred;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_short_gap_defer: assert property (
        state == S_IDLE && burst_end_in && chg_any && !gap_ok
        |=> deferred_out && state == S_IDLE)
        else $error("short gap change not deferred");
    a_rate_gap_go: assert property (
        state == S_IDLE && burst_end_in && (chg_rate || chg_off || chg_rng) && !chg_chan
        && !chg_pwr && gap_sym_in >= GAP_MIN_SYM |=> state == S_RAMP && !deferred_out)
        else $error("96 symbol gap refused for rate change");
    a_mod_gap_go: assert property (
        state == S_IDLE && burst_end_in && chg_mod && !chg_chan && !chg_pwr
        && gap_sym_in >= GAP_MIN_SYM |=> state == S_RAMP)
        else $error("96 symbol gap refused for modulation change");
    a_switch_in_window: assert property (
        $changed(rate_out) || $changed(power_out) || $changed(chan_out)
        || $changed(offset_freq_out) || $changed(rng_offset_out) |-> apply_out)
        else $error("setting switched outside quiet window");
    a_mod_in_window: assert property (
        $changed(qam16_out) |-> apply_out && $past(state, 2) == S_RAMP)
        else $error("modulation switched outside quiet window");
    a_chan_allowance: assert property (
        state == S_IDLE && burst_end_in && chg_chan && gap_ok
        |=> state == S_RAMP && stg_cyc == 24'(CHAN_SETTLE_CYCLES))
        else $error("channel change not staged with its settle time");
    a_small_pwr_settle: assert property (
        apply_out && stg_cyc == PWR_SMALL_CYC |-> ##[1:60] state == S_IDLE)
        else $error("small power change not settled in time");
    a_big_pwr_settle: assert property (
        apply_out && stg_cyc == PWR_BIG_CYC |-> ##[51:110] state == S_IDLE)
        else $error("large power change settle time wrong");
    a_power_range: assert property (
        power_out >= PWR_MIN_DBMV && power_out <= PWR_MAX_QPSK_DBMV
        && (!qam16_out || power_out <= PWR_MAX_QAM16_DBMV))
        else $error("power outside commanded range");
    a_half_step_none: assert property (
        pwr_step_qdb_in == 8'sh02 || pwr_step_qdb_in == -8'sh02 |-> step_db == 7'sh00)
        else $error("half step not rounded to zero");
    a_three_q_round: assert property (
        pwr_step_qdb_in == 8'sh03 |-> step_db == 7'sh01)
        else $error("0.75 dB step not rounded to 1 dB");
    a_power_held_idle: assert property (
        state == S_IDLE && $past(state) == S_IDLE |-> $stable(power_out))
        else $error("power moved outside the gap");
    a_neg_rng_later: assert property (
        state == S_APPLY && stg_adj < 16'sh0000 && rng_offset_out != 16'h0000
        |=> rng_offset_out < $past(rng_offset_out))
        else $error("negative ranging adjustment did not lower offset");
    a_no_change_nogap: assert property (
        state == S_IDLE && burst_end_in && !chg_any |=> state == S_IDLE && !deferred_out)
        else $error("unchanged profile started reconfiguration");

    c_rate_change: cover property (apply_out && $changed(rate_out));
    c_deferred: cover property (deferred_out ##[1:200] apply_out);
    c_big_power: cover property (apply_out && stg_cyc == PWR_BIG_CYC);
endmodule
`default_nettype wire

// ==== test/grant_sched_model.sv ====
// scheduler model that issues upstream grants to the reconfiguration block
`timescale 1ns/1ps
`default_nettype none
module grant_sched_model (
    input wire logic clk_in,
    input wire logic busy_in,
    output logic burst_end_out,
    output logic [15:0] gap_sym_out,
    output logic [2:0] rate_out,
    output logic signed [15:0] offset_freq_out,
    output logic signed [15:0] rng_adj_out,
    output logic qam16_out,
    output logic [31:0] chan_out,
    output logic signed [7:0] step_qdb_out
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial begin
        burst_end_out = 1'b0;
        gap_sym_out = 16'hffff;
        rate_out = 3'h0;
        offset_freq_out = 16'sh0000;
        rng_adj_out = 16'sh0000;
        qam16_out = 1'b0;
        chan_out = 32'h0000_0000;
        step_qdb_out = 8'sh00;
    end
    // ----------------------------------------
    // one grant, called just after a falling edge
    // ----------------------------------------
    task automatic grant(input logic [15:0] gap, input logic [2:0] rate,
        input logic signed [15:0] off, input logic signed [15:0] adj, input logic qam,
        input logic [31:0] chan, input logic signed [7:0] step, output logic late);
        for (int i = 0; i < 5000 && busy_in !== 1'b0; i++) begin
            @(negedge clk_in);
        end
        late = busy_in !== 1'b0;
        burst_end_out = 1'b1;
        gap_sym_out = (adj < 0) ? gap - adj : gap;
        rate_out = rate;
        offset_freq_out = off;
        rng_adj_out = adj;
        qam16_out = qam;
        chan_out = chan;
        step_qdb_out = step;
        @(negedge clk_in);
        burst_end_out = 1'b0;
        gap_sym_out = ~gap_sym_out;
    endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the inter-burst reconfiguration sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import burst_reconfig_pkg::*;
    logic clk_in, rstn_in, burst_end, qam16_out, apply_out, busy_out, deferred_out, nqam;
    logic [15:0] gap_sym, rng_offset_out;
    logic [2:0] next_rate, rate_out, nrate;
    logic signed [15:0] next_off, rng_adj, offset_freq_out, noff, nadj;
    logic next_qam;
    logic [31:0] next_chan, chan_out, nchan;
    logic signed [7:0] pwr_step, nstep;
    logic [5:0] power_out;
    logic [73:0] outs, e_old;
    int n_errors, checked, settle;
    assign outs = {rate_out, offset_freq_out, rng_offset_out, qam16_out, chan_out, power_out};
    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    grant_sched_model sched_u (.clk_in(clk_in), .busy_in(busy_out), .burst_end_out(burst_end),
        .gap_sym_out(gap_sym), .rate_out(next_rate), .offset_freq_out(next_off),
        .rng_adj_out(rng_adj), .qam16_out(next_qam), .chan_out(next_chan),
        .step_qdb_out(pwr_step));
    upstream_burst_reconfig_power #(.CHAN_SETTLE_CYCLES(200), .RAMP_SYMBOLS(8'h02)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .burst_end_in(burst_end), .gap_sym_in(gap_sym),
        .next_rate_in(next_rate), .next_offset_freq_in(next_off), .rng_adj_in(rng_adj),
        .next_qam16_in(next_qam), .next_chan_in(next_chan), .pwr_step_qdb_in(pwr_step),
        .rate_out(rate_out), .offset_freq_out(offset_freq_out), .rng_offset_out(rng_offset_out),
        .qam16_out(qam16_out), .chan_out(chan_out), .power_out(power_out),
        .apply_out(apply_out), .busy_out(busy_out), .deferred_out(deferred_out));
    // ----------------------------------------
    // compare, verdict and one grant with its expected outcome
    // ----------------------------------------
    task automatic check(input logic [73:0] seen, input logic [73:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // mode 0 no change, 1 refused, 2 accepted
    task automatic go(input logic [15:0] gap, input int mode, input logic [5:0] pwr);
        logic [73:0] e_new;
        int n;
        logic late;
        e_new = {nrate, noff, e_old[54:39] + nadj, nqam, nchan, pwr};
        n = 0;
        settle = 0;
        sched_u.grant(gap, nrate, noff, nadj, nqam, nchan, nstep, late);
        @(posedge clk_in);
        @(negedge clk_in);
        check(74'(deferred_out), 74'(mode == 1));
        check(74'(busy_out), 74'(mode == 2));
        check(outs, e_old);
        if (mode == 2) begin
            for (n = 0; n < 3000 && apply_out !== 1'b1; n++) begin
                @(negedge clk_in);
            end
            check(outs, e_new);
            e_old = e_new;
            for (settle = 0; settle < 3000 && busy_out === 1'b1; settle++) begin
                @(negedge clk_in);
            end
        end
        if (late || n == 3000 || settle == 3000) begin
            n_errors++;
            end_of_test;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_errors = 0;
        checked = 0;
        nrate = 3'h0;
        noff = 16'sh0000;
        nadj = 16'sh0000;
        nqam = 1'b0;
        nchan = 32'h0000_0000;
        nstep = 8'sh00;
        e_old = {3'h0, 16'h0000, 16'h0000, 1'b0, 32'h0000_0000, 6'h08};
        rstn_in = 1'b0;
        repeat (12) @(negedge clk_in);
        rstn_in = 1'b1;
        check(outs, e_old);
        go(16'h0000, 0, 6'h08);
        nstep = 8'sh02;
        go(16'h0000, 0, 6'h08);
        nstep = -8'sh02;
        go(16'h0000, 0, 6'h08);
        nstep = 8'sh04;
        go(16'h0060, 1, 6'h08);
        go(16'h0061, 2, 6'h09);
        check(74'(settle >= 50 && settle <= 53), 74'(1'b1));
        nstep = 8'sh08;
        go(16'h0061, 1, 6'h09);
        go(16'h0062, 2, 6'h0b);
        check(74'(settle >= 100 && settle <= 103), 74'(1'b1));
        nstep = 8'sh03;
        go(16'h0062, 2, 6'h0c);
        nstep = -8'sh03;
        go(16'h0062, 2, 6'h0b);
        nstep = 8'sh7f;
        go(16'h0062, 2, 6'h2b);
        go(16'h0062, 2, 6'h3a);
        nstep = -8'sh80;
        go(16'h0062, 2, 6'h1a);
        go(16'h0062, 2, 6'h08);
        nstep = 8'sh04;
        nchan = 32'h1234_5678;
        go(16'h3edf, 1, 6'h08);
        go(16'h3ee0, 2, 6'h09);
        check(74'(settle >= 200 && settle <= 203), 74'(1'b1));
        nstep = 8'sh00;
        nadj = 16'sh0064;
        go(16'h0060, 2, 6'h09);
        nadj = -16'sh0028;
        go(16'h0060, 2, 6'h09);
        nadj = 16'sh0000;
        noff = 16'sh0100;
        go(16'h005f, 1, 6'h09);
        go(16'h0060, 2, 6'h09);
        check(74'(settle <= 3), 74'(1'b1));
        nqam = 1'b1;
        go(16'h005f, 1, 6'h09);
        go(16'h0060, 2, 6'h09);
        nstep = 8'sh7f;
        go(16'h0062, 2, 6'h29);
        go(16'h0062, 2, 6'h37);
        nstep = -8'sh80;
        go(16'h0062, 2, 6'h17);
        nstep = -8'sh38;
        go(16'h0062, 2, 6'h09);
        nstep = 8'sh00;
        nrate = 3'h4;
        go(16'h005f, 1, 6'h09);
        go(16'h0060, 2, 6'h09);
        nstep = 8'sh04;
        go(16'h006c, 1, 6'h09);
        go(16'h006d, 2, 6'h0a);
        end_of_test;
    end
endmodule
`default_nettype wire
